// ==== dmasg_defines.svh ====
`ifndef DMASG_DEFINES_SVH
`define DMASG_DEFINES_SVH

// Cycle-type codes
`define DMASG_CT_INVALID 3'h0
`define DMASG_CT_BASIC   3'h1
`define DMASG_CT_AUTO    3'h2
`define DMASG_CT_MSG_PRI 3'h4
`define DMASG_CT_MSG_ALT 3'h5
`define DMASG_CT_PSG_PRI 3'h6
`define DMASG_CT_PSG_ALT 3'h7

// Descriptor word offsets
`define DMASG_W_SRC 4'h0
`define DMASG_W_DST 4'h4
`define DMASG_W_CFG 4'h8

// Address increment and size codes
`define DMASG_INC_WORD  2'h2
`define DMASG_INC_NONE  2'h3
`define DMASG_SIZE_WORD 2'h2

// Copy and chunk geometry
`define DMASG_COPY_LAST  2'h3
`define DMASG_COPY_STEP  10'h004
`define DMASG_RATE_MAX   4'ha
`define DMASG_CHUNK_MAX  11'h3ff

// Register offsets
`define DMASG_OFF_BASE   8'h00
`define DMASG_OFF_CHEN   8'h04
`define DMASG_OFF_SWREQ  8'h08
`define DMASG_OFF_BURST  8'h0c
`define DMASG_OFF_STATUS 8'h10

// Reset values
`define DMASG_BASE_RST 32'h0000_0000
`define DMASG_CHEN_RST 8'h00

`endif

// ==== dmasg_pkg.sv ====
package dmasg_pkg;

  typedef enum logic [3:0] {
    ST_ARB, ST_FSRC, ST_FDST, ST_FCFG, ST_DEC,
    ST_CRD, ST_CFL, ST_CWR, ST_CWB,
    ST_TRD, ST_TCAP, ST_TWR, ST_TWB
  } dmasg_state_t;

  typedef struct packed {
    logic [1:0] dst_inc;
    logic [1:0] dst_size;
    logic [1:0] src_inc;
    logic [1:0] src_size;
    logic [2:0] dst_prot;
    logic [2:0] src_prot;
    logic [3:0] arb_rate;
    logic [9:0] n_minus_1;
    logic       burst_next;
    logic [2:0] cycle;
  } dmasg_cfg_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic        prot;
    logic [1:0]  size;
  } dmasg_mreq_t;

endpackage

// ==== dmasg_buf.sv ====
`timescale 1ns/1ps
module dmasg_buf #(
  parameter int W  = 32,
  parameter int AW = 2
) (
  input  wire logic          sys_clk,  // Core clock
  input  wire logic          wr_en,    // Write strobe
  input  wire logic [AW-1:0] wr_addr,  // Write index
  input  wire logic [W-1:0]  wr_data,  // Write word
  input  wire logic [AW-1:0] rd_addr,  // Read index
  output logic      [W-1:0]  rd_data   // Registered read word
);
  logic [W-1:0] mem_r [2**AW];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
    rd_data <= mem_r[rd_addr];
  end
endmodule

// ==== dmasg_seq.sv ====
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "dmasg_defines.svh"
module dmasg_seq #(
  parameter int NCH = 8
) (
  input  wire logic               sys_clk,    // Core clock, 10 MHz
  input  wire logic               reset,      // Async reset, active high
  input  wire logic [7:0]         reg_addr,   // Register byte address
  input  wire logic [31:0]        reg_wdata,  // Register write data
  input  wire logic               reg_wr,     // Register write strobe
  input  wire logic               reg_rd,     // Register read strobe
  output logic      [31:0]        reg_rdata,  // Read data, cycle after strobe
  input  wire logic [NCH-1:0]     dma_req,    // Peripheral request lines
  output dmasg_pkg::dmasg_mreq_t  mem_req,    // System bus request
  input  wire logic [31:0]        mem_rdata,  // Bus read data, cycle after read
  output logic      [NCH-1:0]     dma_done    // Per-channel done pulse
);
  typedef dmasg_pkg::dmasg_state_t dmasg_st_t;

  dmasg_st_t              state_r, state_nxt;
  dmasg_pkg::dmasg_cfg_t  cfg_r, cfg_nxt, cfg_in;
  logic [2:0]             ch_r, ch_nxt, ctype_r, ctype_nxt;
  logic                   trig_r, trig_nxt, last_r, last_nxt;
  logic [1:0]             idx_r, idx_nxt;
  logic [10:0]            cnt_r, cnt_nxt;
  logic [31:0]            src_r, src_nxt, dst_r, dst_nxt;
  logic [31:0]            data_r, data_nxt, base_r, base_nxt, rdata_r;
  logic [NCH-1:0]         alt_r, alt_nxt, auto_r, auto_nxt, swp_r, swp_nxt;
  logic [NCH-1:0]         en_r, en_nxt, nub_r, nub_nxt, ubf_r, ubf_nxt;
  logic [NCH-1:0]         done_r, done_nxt, sy1_r, sy2_r;
  logic [31:0]            buf_rdata;

  function automatic logic [31:0] xfer_addr(logic [31:0] endp, logic [9:0] rem,
                                            logic [1:0] inc);
    xfer_addr = (inc == `DMASG_INC_NONE) ? endp : endp - ({22'h0, rem} << inc);
  endfunction

  function automatic logic [2:0] first_set(logic [NCH-1:0] v);
    first_set = 3'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 3'(i);
      end
    end
  endfunction

  function automatic logic [10:0] chunk_last(logic [3:0] r);
    chunk_last = (r >= `DMASG_RATE_MAX) ? `DMASG_CHUNK_MAX : 11'((11'h1 << r) - 11'h1);
  endfunction

  // Lowest channel index wins arbitration
  wire [NCH-1:0] pend     = en_r & (sy2_r | swp_r | auto_r);
  wire [2:0]     gnt      = first_set(pend);
  wire           cur_alt  = alt_r[ch_r];
  wire [9:0]     nm1      = cfg_r.n_minus_1;
  assign cfg_in = dmasg_pkg::dmasg_cfg_t'(mem_rdata);

  wire s_fsrc  = state_r == dmasg_pkg::ST_FSRC;
  wire s_fdst  = state_r == dmasg_pkg::ST_FDST;
  wire s_fcfg  = state_r == dmasg_pkg::ST_FCFG;
  wire s_crd   = state_r == dmasg_pkg::ST_CRD;
  wire s_cfl   = state_r == dmasg_pkg::ST_CFL;
  wire s_cwr   = state_r == dmasg_pkg::ST_CWR;
  wire s_trd   = state_r == dmasg_pkg::ST_TRD;
  wire s_twr   = state_r == dmasg_pkg::ST_TWR;
  wire s_wb    = state_r == dmasg_pkg::ST_CWB || state_r == dmasg_pkg::ST_TWB;

  wire [3:0]  dword  = s_fdst ? `DMASG_W_DST : (s_fsrc ? `DMASG_W_SRC : `DMASG_W_CFG);
  wire [31:0] desc_a = {base_r[31:8], cur_alt, ch_r, dword};
  wire [31:0] alt_a  = {base_r[31:8], 1'b1, ch_r, idx_r, 2'h0};
  wire [31:0] copy_a = xfer_addr(src_r, nm1 - 10'(idx_r), `DMASG_INC_WORD);
  wire [31:0] tsrc_a = xfer_addr(src_r, nm1, cfg_r.src_inc);
  wire [31:0] tdst_a = xfer_addr(dst_r, nm1, cfg_r.dst_inc);

  assign mem_req.rd    = s_fsrc || s_fdst || s_fcfg || s_crd || s_trd;
  assign mem_req.wr    = s_cwr || s_twr || s_wb;
  assign mem_req.addr  = s_crd ? copy_a : s_cwr ? alt_a : s_trd ? tsrc_a :
                         s_twr ? tdst_a : desc_a;
  assign mem_req.wdata = s_cwr ? buf_rdata : s_twr ? data_r : cfg_r;
  assign mem_req.prot  = (s_crd || s_trd) ? cfg_r.src_prot[0] :
                         (s_cwr || s_twr) ? cfg_r.dst_prot[0] : 1'b0;
  assign mem_req.size  = (s_trd || s_twr) ? cfg_r.src_size : `DMASG_SIZE_WORD;

  // Copy staging: four words read, then four written
  wire       bwe = (s_crd && idx_r != 2'h0) || s_cfl;
  wire [1:0] bwa = s_cfl ? `DMASG_COPY_LAST : 2'(idx_r - 2'h1);
  wire [1:0] bra = s_cfl ? 2'h0 : 2'(idx_r + 2'h1);

  dmasg_buf #(.W(32), .AW(2)) u_buf (
    .sys_clk (sys_clk),
    .wr_en   (bwe),
    .wr_addr (bwa),
    .wr_data (mem_rdata),
    .rd_addr (bra),
    .rd_data (buf_rdata)
  );

  wire           wr_base  = reg_wr && reg_addr == `DMASG_OFF_BASE;
  wire           wr_chen  = reg_wr && reg_addr == `DMASG_OFF_CHEN;
  wire           wr_swreq = reg_wr && reg_addr == `DMASG_OFF_SWREQ;
  wire           wr_burst = reg_wr && reg_addr == `DMASG_OFF_BURST;
  wire [NCH-1:0] wbits    = reg_wdata[NCH-1:0];
  wire [31:0]    status   = {8'h0, 8'(auto_r), 8'(alt_r), 4'h0,
                             state_r != dmasg_pkg::ST_ARB, ch_r};
  wire [31:0]    rd_mux   = (reg_addr == `DMASG_OFF_BASE)   ? base_r :
                            (reg_addr == `DMASG_OFF_CHEN)   ? 32'(en_r) :
                            (reg_addr == `DMASG_OFF_BURST)  ? 32'(ubf_r) :
                            (reg_addr == `DMASG_OFF_STATUS) ? status : 32'h0000_0000;

  always_comb begin
    state_nxt = state_r;
    cfg_nxt   = cfg_r;
    ch_nxt    = ch_r;
    ctype_nxt = ctype_r;
    trig_nxt  = trig_r;
    last_nxt  = last_r;
    idx_nxt   = idx_r;
    cnt_nxt   = cnt_r;
    src_nxt   = src_r;
    dst_nxt   = dst_r;
    data_nxt  = data_r;
    alt_nxt   = alt_r;
    auto_nxt  = auto_r;
    swp_nxt   = swp_r;
    en_nxt    = en_r;
    nub_nxt   = nub_r;
    done_nxt  = '0;
    ubf_nxt   = ubf_r & ~(wr_burst ? wbits : '0);
    case (state_r)
      dmasg_pkg::ST_ARB: begin
        if (|pend) begin
          ch_nxt        = gnt;
          trig_nxt      = sy2_r[gnt];
          auto_nxt[gnt] = 1'b0;
          swp_nxt[gnt]  = 1'b0;
          state_nxt     = dmasg_pkg::ST_FSRC;
        end
      end
      dmasg_pkg::ST_FSRC: state_nxt = dmasg_pkg::ST_FDST;
      dmasg_pkg::ST_FDST: begin
        src_nxt   = mem_rdata;
        state_nxt = dmasg_pkg::ST_FCFG;
      end
      dmasg_pkg::ST_FCFG: begin
        dst_nxt   = mem_rdata;
        state_nxt = dmasg_pkg::ST_DEC;
      end
      dmasg_pkg::ST_DEC: begin
        cfg_nxt   = cfg_in;
        ctype_nxt = cfg_in.cycle;
        idx_nxt   = 2'h0;
        cnt_nxt   = 11'h000;
        state_nxt = dmasg_pkg::ST_ARB;
        if (!cur_alt) begin
          if (cfg_in.cycle == `DMASG_CT_MSG_PRI ||
              (cfg_in.cycle == `DMASG_CT_PSG_PRI && trig_r)) begin
            state_nxt = dmasg_pkg::ST_CRD;
          end
        end else if (cfg_in.cycle == `DMASG_CT_MSG_ALT || cfg_in.cycle == `DMASG_CT_PSG_ALT ||
                     cfg_in.cycle == `DMASG_CT_AUTO || cfg_in.cycle == `DMASG_CT_BASIC) begin
          state_nxt = dmasg_pkg::ST_TRD;
        end else begin
          alt_nxt[ch_r] = 1'b0;
        end
      end
      dmasg_pkg::ST_CRD: begin
        idx_nxt = 2'(idx_r + 2'h1);
        if (idx_r == `DMASG_COPY_LAST) begin
          state_nxt = dmasg_pkg::ST_CFL;
        end
      end
      dmasg_pkg::ST_CFL: begin
        last_nxt          = nm1 < `DMASG_COPY_STEP;
        cfg_nxt.n_minus_1 = last_nxt ? 10'h000 : 10'(nm1 - `DMASG_COPY_STEP);
        if (last_nxt) begin
          cfg_nxt.cycle = `DMASG_CT_INVALID;
        end
        nub_nxt[ch_r] = cfg_r.burst_next;
        state_nxt     = dmasg_pkg::ST_CWR;
      end
      dmasg_pkg::ST_CWR: begin
        idx_nxt = 2'(idx_r + 2'h1);
        if (idx_r == `DMASG_COPY_LAST) begin
          state_nxt = dmasg_pkg::ST_CWB;
        end
      end
      dmasg_pkg::ST_CWB: begin
        alt_nxt[ch_r] = 1'b1;
        if (ctype_r == `DMASG_CT_PSG_PRI) begin
          state_nxt = dmasg_pkg::ST_FSRC;
        end else begin
          auto_nxt[ch_r] = 1'b1;
          state_nxt      = dmasg_pkg::ST_ARB;
        end
      end
      dmasg_pkg::ST_TRD: state_nxt = dmasg_pkg::ST_TCAP;
      dmasg_pkg::ST_TCAP: begin
        data_nxt  = mem_rdata;
        state_nxt = dmasg_pkg::ST_TWR;
      end
      dmasg_pkg::ST_TWR: begin
        cnt_nxt  = 11'(cnt_r + 11'h001);
        last_nxt = nm1 == 10'h000;
        if (last_nxt) begin
          cfg_nxt.cycle = `DMASG_CT_INVALID;
        end else begin
          cfg_nxt.n_minus_1 = 10'(nm1 - 10'h001);
        end
        state_nxt = (last_nxt || cnt_r == chunk_last(cfg_r.arb_rate)) ?
                    dmasg_pkg::ST_TWB : dmasg_pkg::ST_TRD;
      end
      dmasg_pkg::ST_TWB: begin
        state_nxt = dmasg_pkg::ST_ARB;
        if (!last_r) begin
          // Peripheral-paced chunks wait for a fresh request
          if (ctype_r == `DMASG_CT_AUTO || ctype_r == `DMASG_CT_MSG_ALT) begin
            auto_nxt[ch_r] = 1'b1;
          end
        end else begin
          alt_nxt[ch_r] = 1'b0;
          case (ctype_r)
            `DMASG_CT_MSG_ALT: auto_nxt[ch_r] = 1'b1;
            `DMASG_CT_PSG_ALT: ubf_nxt[ch_r]  = ubf_nxt[ch_r] | nub_r[ch_r];
            default: begin
              done_nxt[ch_r] = 1'b1;
              en_nxt[ch_r]   = 1'b0;
            end
          endcase
        end
      end
      default: state_nxt = dmasg_pkg::ST_ARB;
    endcase
    // Software set lands after any hardware clear
    swp_nxt = swp_nxt | (wr_swreq ? wbits : '0);
    if (wr_chen) begin
      en_nxt = wbits;
    end
  end

  assign base_nxt  = wr_base ? {reg_wdata[31:8], 8'h00} : base_r;
  assign reg_rdata = rdata_r;
  assign dma_done  = done_r;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sy1_r <= '0;
      sy2_r <= '0;
    end else begin
      sy1_r <= dma_req;
      sy2_r <= sy1_r;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= dmasg_pkg::ST_ARB;
      cfg_r   <= '0;
      ch_r    <= 3'h0;
      ctype_r <= `DMASG_CT_INVALID;
      trig_r  <= 1'b0;
      last_r  <= 1'b0;
      idx_r   <= 2'h0;
      cnt_r   <= 11'h000;
      src_r   <= 32'h0000_0000;
      dst_r   <= 32'h0000_0000;
      data_r  <= 32'h0000_0000;
      base_r  <= `DMASG_BASE_RST;
      rdata_r <= 32'h0000_0000;
      alt_r   <= '0;
      auto_r  <= '0;
      swp_r   <= '0;
      en_r    <= NCH'(`DMASG_CHEN_RST);
      nub_r   <= '0;
      ubf_r   <= '0;
      done_r  <= '0;
    end else begin
      state_r <= state_nxt;
      cfg_r   <= cfg_nxt;
      ch_r    <= ch_nxt;
      ctype_r <= ctype_nxt;
      trig_r  <= trig_nxt;
      last_r  <= last_nxt;
      idx_r   <= idx_nxt;
      cnt_r   <= cnt_nxt;
      src_r   <= src_nxt;
      dst_r   <= dst_nxt;
      data_r  <= data_nxt;
      base_r  <= base_nxt;
      rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
      alt_r   <= alt_nxt;
      auto_r  <= auto_nxt;
      swp_r   <= swp_nxt;
      en_r    <= en_nxt;
      nub_r   <= nub_nxt;
      ubf_r   <= ubf_nxt;
      done_r  <= done_nxt;
    end
  end

  done_pulse_a: assert property (@(posedge sys_clk) disable iff (reset)
    |done_r |=> !(|done_r) && state_r != dmasg_pkg::ST_TWB)
    else $error("done held longer than one cycle");

  done_cause_a: assert property (@(posedge sys_clk) disable iff (reset)
    |done_r |-> $past(state_r == dmasg_pkg::ST_TWB && last_r &&
      (ctype_r == `DMASG_CT_AUTO || ctype_r == `DMASG_CT_BASIC)))
    else $error("done without final auto or basic task");

  copy_target_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_cwr |-> mem_req.wr && mem_req.addr[7] && mem_req.addr[6:4] == ch_r)
    else $error("copy not aimed at own alternate descriptor");

  psg_direct_a: assert property (@(posedge sys_clk) disable iff (reset)
    state_r == dmasg_pkg::ST_CWB && ctype_r == `DMASG_CT_PSG_PRI
    |=> s_fsrc && cur_alt ##3 state_r == dmasg_pkg::ST_DEC)
    else $error("peripheral copy did not start alternate at once");

  msg_auto_a: assert property (@(posedge sys_clk) disable iff (reset)
    state_r == dmasg_pkg::ST_CWB && ctype_r == `DMASG_CT_MSG_PRI
    |=> auto_r[$past(ch_r)] && state_r == dmasg_pkg::ST_ARB)
    else $error("memory copy missed its auto-request");

  pri_invalid_a: assert property (@(posedge sys_clk) disable iff (reset)
    state_r == dmasg_pkg::ST_CWB && last_r |-> mem_req.wdata[2:0] == `DMASG_CT_INVALID)
    else $error("final copy left primary valid");

  psg_swonly_a: assert property (@(posedge sys_clk) disable iff (reset)
    state_r == dmasg_pkg::ST_DEC && !cur_alt && !trig_r &&
    cfg_in.cycle == `DMASG_CT_PSG_PRI |=> state_r == dmasg_pkg::ST_ARB)
    else $error("software request started peripheral sequence");

  read_prot_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_trd |-> mem_req.rd && mem_req.prot == cfg_r.src_prot[0])
    else $error("source read protection wrong");

  copy_len_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_crd && idx_r == 2'h0 |-> s_crd [*4] ##1 s_cfl ##1 s_cwr [*4])
    else $error("copy is not four sequential words");

  chunk_arb_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_twr && !last_nxt && cnt_r == chunk_last(cfg_r.arb_rate)
    |=> state_r == dmasg_pkg::ST_TWB ##1 state_r == dmasg_pkg::ST_ARB)
    else $error("chunk end did not re-arbitrate");

  msg_next_a: assert property (@(posedge sys_clk) disable iff (reset)
    state_r == dmasg_pkg::ST_TWB && last_r && ctype_r == `DMASG_CT_MSG_ALT
    |=> auto_r[$past(ch_r)] && !alt_r[$past(ch_r)] && !(|done_r))
    else $error("memory task end mishandled");
endmodule

// ==== dmasg_mem.sv ====
`timescale 1ns/1ps
module dmasg_mem #(
  parameter int DEPTH = 1024
) (
  input  wire logic                   sys_clk,   // Core clock
  input  wire dmasg_pkg::dmasg_mreq_t mem_req,   // Bus request from sequencer
  output logic [31:0]                 mem_rdata  // Read data, cycle after read
);
  logic [31:0] mem [DEPTH];
  logic [31:0] rd_q = 32'h5a5a_a5a5;
  logic [9:0]  idx;

  assign idx       = mem_req.addr[11:2];
  assign mem_rdata = rd_q;

  // Outside a read the word flips each cycle, so stale data never passes as valid
  always @(posedge sys_clk) begin
    if (mem_req.rd) begin
      rd_q <= mem[idx];
    end else begin
      rd_q <= ~rd_q;
    end
    if (mem_req.wr) begin
      mem[idx] <= mem_req.wdata;
    end
  end
endmodule

// ==== dmasg_seq_tb.sv ====
`timescale 1ns/1ps
`include "dmasg_defines.svh"
module dmasg_seq_tb;
  logic                   sys_clk;
  logic                   reset;
  logic [7:0]             reg_addr;
  logic [31:0]            reg_wdata;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [31:0]            reg_rdata;
  logic [7:0]             dma_req;
  dmasg_pkg::dmasg_mreq_t mem_req;
  logic [31:0]            mem_rdata;
  logic [7:0]             dma_done;
  logic [2:0]             dp3;
  logic [2:0]             sp3;
  int                     n_fail;
  int                     compares;
  int                     cycles;
  int                     wr_cnt;

  dmasg_seq #(.NCH(8)) dmasg_seq_inst (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_req(dma_req),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .dma_done(dma_done));

  dmasg_mem dmasg_mem_inst (.sys_clk(sys_clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_check(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask

  function automatic logic [31:0] mk_cfg(input logic [2:0] cyc, input logic [3:0] r,
                                         input logic [9:0] nm1, input logic brst);
    dmasg_pkg::dmasg_cfg_t c;
    c            = '0;
    c.dst_inc    = `DMASG_INC_WORD;
    c.dst_size   = `DMASG_SIZE_WORD;
    c.src_inc    = `DMASG_INC_WORD;
    c.src_size   = `DMASG_SIZE_WORD;
    c.dst_prot   = dp3;
    c.src_prot   = sp3;
    c.arb_rate   = r;
    c.n_minus_1  = nm1;
    c.burst_next = brst;
    c.cycle      = cyc;
    return c;
  endfunction

  // Checked at the falling edge, where the decoded bus request has settled
  always @(negedge sys_clk) begin
    if (!reset && mem_req.wr) begin
      wr_cnt++;
    end
    if (!reset && mem_req.wr && mem_req.addr[11]) begin
      chk("dst prot", {31'h0, dp3[0]}, {31'h0, mem_req.prot});
    end
    if (!reset && mem_req.rd && mem_req.addr[11:10] == 2'h1) begin
      chk("src prot", {31'h0, sp3[0]}, {31'h0, mem_req.prot});
    end
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic run_sg(input logic periph, input logic sw, input int ntask, input logic brst);
    int          nk[4];
    int          ch;
    int          pw;
    int          t;
    int          snap;
    logic [2:0]  cyc;
    logic [31:0] se;
    logic [31:0] de;
    ch  = $urandom_range(7);
    pw  = 32'h40 + ch * 4;
    dp3 = 3'($urandom);
    sp3 = 3'($urandom);
    for (int k = 0; k < ntask; k++) begin
      nk[k] = $urandom_range(6, 1);
      for (int i = 0; i < nk[k]; i++) begin
        dmasg_mem_inst.mem[32'h100 + k * 16 + i] = $urandom;
        dmasg_mem_inst.mem[32'h200 + k * 16 + i] = ~dmasg_mem_inst.mem[32'h100 + k * 16 + i];
      end
      se  = 32'h400 + k * 64 + (nk[k] - 1) * 4;
      de  = 32'h800 + k * 64 + (nk[k] - 1) * 4;
      cyc = periph ? ((k == ntask - 1) ? `DMASG_CT_BASIC : `DMASG_CT_PSG_ALT)
                   : ((k == ntask - 1) ? `DMASG_CT_AUTO : `DMASG_CT_MSG_ALT);
      dmasg_mem_inst.mem[32'h80 + k * 4]     = se;
      dmasg_mem_inst.mem[32'h80 + k * 4 + 1] = de;
      dmasg_mem_inst.mem[32'h80 + k * 4 + 2] = mk_cfg(cyc, 4'($urandom_range(3)),
                                                      10'(nk[k] - 1), 1'b0);
      dmasg_mem_inst.mem[32'h80 + k * 4 + 3] = $urandom;
    end
    dmasg_mem_inst.mem[pw]     = 32'h200 + ntask * 16 - 4;
    dmasg_mem_inst.mem[pw + 1] = 32'h0000_0000;
    // Word copies, four per burst, count a multiple of four
    dmasg_mem_inst.mem[pw + 2] = mk_cfg(periph ? `DMASG_CT_PSG_PRI : `DMASG_CT_MSG_PRI,
                                        4'h2, 10'(4 * ntask - 1), periph & brst);
    reg_write(`DMASG_OFF_BASE, 32'h0000_0100);
    reg_write(`DMASG_OFF_CHEN, 32'(1 << ch));
    if (periph) begin
      snap = wr_cnt;
      reg_write(`DMASG_OFF_SWREQ, 32'(1 << ch));
      repeat (40) @(posedge sys_clk);
      chk("sw start writes", 32'(snap), 32'(wr_cnt));
      chk("sw start dones", 32'h0, {24'h0, dma_done});
    end
    if (sw) begin
      reg_write(`DMASG_OFF_SWREQ, 32'(1 << ch));
    end else begin
      @(posedge sys_clk);
      dma_req <= 8'(1 << ch);
    end
    t = 0;
    while (dma_done === 8'h00 && t < 5000) begin
      @(posedge sys_clk);
      #1;
      t++;
    end
    chk("done channel", 32'(1 << ch), {24'h0, dma_done});
    for (int k = 0; k < ntask; k++) begin
      for (int i = 0; i < nk[k]; i++) begin
        chk("dst word", dmasg_mem_inst.mem[32'h100 + k * 16 + i],
            dmasg_mem_inst.mem[32'h200 + k * 16 + i]);
      end
    end
    @(posedge sys_clk);
    dma_req <= 8'h00;
    #1;
    chk("done width", 32'h0, {24'h0, dma_done});
    chk("primary cycle", 32'h0, {29'h0, dmasg_mem_inst.mem[pw + 2][2:0]});
    chk("alt src", se, dmasg_mem_inst.mem[32'h60 + ch * 4]);
    chk("alt dst", de, dmasg_mem_inst.mem[32'h61 + ch * 4]);
    reg_check("chen after done", `DMASG_OFF_CHEN, 32'h0000_0000);
    reg_check("status idle", `DMASG_OFF_STATUS, 32'(ch));
    reg_check("burst flag", `DMASG_OFF_BURST, (periph & brst) ? 32'(1 << ch) : 32'h0);
    reg_write(`DMASG_OFF_BURST, 32'(1 << ch));
    reg_check("burst cleared", `DMASG_OFF_BURST, 32'h0000_0000);
  endtask

  initial begin
    reset     = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    dma_req   = 8'h00;
    dp3       = 3'h0;
    sp3       = 3'h0;
    n_fail    = 0;
    compares  = 0;
    cycles    = 0;
    wr_cnt    = 0;
    void'($urandom(53));
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    reg_check("base reset", `DMASG_OFF_BASE, `DMASG_BASE_RST);
    reg_check("chen reset", `DMASG_OFF_CHEN, {24'h0, `DMASG_CHEN_RST});
    reg_write(8'h14, 32'hffff_ffff);
    reg_check("unmapped", 8'h14, 32'h0000_0000);
    reg_check("swreq read", `DMASG_OFF_SWREQ, 32'h0000_0000);
    run_sg(1'b0, 1'b1, 3, 1'b0);
    run_sg(1'b0, 1'b0, 1, 1'b0);
    run_sg(1'b1, 1'b0, 3, 1'b1);
    run_sg(1'b1, 1'b0, 2, 1'b0);
    summarize();
  end
endmodule
